// ===== hdl/vpa_pkg.sv
/*
 Constants for the vector priority arbiter: vector numbers, levels,
 boot locations and address widths.
 Assumes a 100 MHz system clock and synchronous active-high reset.
*/
package vpa_pkg;
   localparam int VPA_NUM_VEC = 64;
   localparam int VPA_VEC_W = 6;
   localparam int VPA_LVL_W = 2;
   localparam int VPA_ADDR_W = 21;
   localparam int VPA_TARGET_W = 19;
   localparam logic [1:0] VPA_LVL_TOP = 2'h3;
   localparam logic [1:0] VPA_LVL_PERIPH_MAX = 2'h2;
   localparam logic [1:0] VPA_LVL_DEBUG_MIN = 2'h1;
   localparam logic [20:0] VPA_BOOT_LOC = 21'h02_0000;
   localparam logic [20:0] VPA_WDOG_LOC = 21'h02_0002;
   localparam logic [15:0] VPA_BASE_RESET = 16'h0200;
   localparam int VPA_BASE_SHIFT = 8;
   localparam int VPA_V_ILLEGAL = 2;
   localparam int VPA_V_SWI3 = 3;
   localparam int VPA_V_STACK = 4;
   localparam int VPA_V_MISALIGN = 5;
   localparam int VPA_V_STEP = 6;
   localparam int VPA_V_BKPT0 = 7;
   localparam int VPA_V_TRACE = 9;
   localparam int VPA_V_TX_EMPTY = 10;
   localparam int VPA_V_RX_FULL = 11;
   localparam int VPA_V_EXT_A = 17;
   localparam int VPA_V_LOWV = 20;
   localparam int VPA_V_CLKSYN = 21;
   localparam int VPA_V_FL_ERR = 22;
   localparam int VPA_V_FL_DONE = 23;
   localparam int VPA_V_FL_EMPTY = 24;
   localparam int VPA_V_CAN_OFF = 26;
   localparam int VPA_V_CAN_ERR = 27;
   localparam int VPA_V_CAN_WAKE = 28;
   localparam int VPA_V_CAN_MB = 29;
   localparam int VPA_V_PORT_C = 33;
   localparam int VPA_V_PORT_B = 34;
   localparam int VPA_V_PORT_A = 35;
   localparam int VPA_V_SERIAL_PERIPH_UNIT_1_RX = 38;
   localparam int VPA_V_SERIAL_PERIPH_UNIT_1_TX = 39;
   localparam int VPA_V_SERIAL_PERIPH_UNIT_0_RX = 40;
   localparam int VPA_V_SERIAL_PERIPH_UNIT_0_TX = 41;
   localparam int VPA_V_ASU1_TX = 42;
   localparam int VPA_V_ASU1_IDLE = 43;
   // Peripheral request lines in order of the inputs, index = request bit
   localparam int VPA_NUM_PER = 24;
   typedef enum logic [1:0] {VPA_IDLE, VPA_HOLD} vpa_state_e;
endpackage

// ===== hdl/vector_priority_arbiter.sv
/*
 Interrupt prioritisation and vector generation: ranks core exceptions,
 debug and peripheral requests, presents the winner to the core and holds
 it until acknowledged. Also gives the reset and watchdog entry points.
 Assumes requests are levels synchronous to ref_clk_i except the external
 request, which is synchronised here outside stop and wait.
*/
module vector_priority_arbiter
   import vpa_pkg::*;
#(
   parameter int NUM_VEC = VPA_NUM_VEC
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Core exceptions, fixed top level
   input wire logic [3:0] core_exc_i,
   // Debug unit requests: step, breakpoint 0, trace, tx empty, rx full
   input wire logic [4:0] debug_unit_req_i,
   input wire logic [9:0] debug_unit_lvl_i,
   // External request pin and its configuration
   input wire logic external_request_a_n_i,
   input wire logic ext_edge_mode_i,
   input wire logic ext_low_power_i,
   input wire logic [1:0] ext_lvl_i,
   // Peripheral requests and levels, 2 bits per request
   input wire logic [vpa_pkg::VPA_NUM_PER-1:0] periph_req_i,
   input wire logic [2*vpa_pkg::VPA_NUM_PER-1:0] periph_lvl_i,
   // Vector base and operating mode register
   input wire logic [15:0] vector_base_address_i,
   input wire logic boot_select_bit_i,
   input wire logic flash_secure_i,
   input wire logic mode_wr_i,
   input wire logic mode_wr_data_i,
   // Core side
   input wire logic core_ack_i,
   output logic irq_valid_o,
   output logic [vpa_pkg::VPA_VEC_W-1:0] irq_vector_o,
   output logic [1:0] irq_level_o,
   output logic [vpa_pkg::VPA_ADDR_W-1:0] irq_addr_o,
   output logic [vpa_pkg::VPA_ADDR_W-1:0] boot_addr_o,
   output logic [vpa_pkg::VPA_ADDR_W-1:0] wdog_addr_o,
   output logic flash_security_bit_o,
   output logic ext_pending_o
);
   import vpa_pkg::*;

   initial begin
      if (NUM_VEC != VPA_NUM_VEC)
      begin
         $error("NUM_VEC must equal the vector table size");
      end
   end

   // Entry address: base (word units of 256) plus twice the vector
   function automatic logic [20:0] entry_addr(input logic [15:0] base,
                                              input logic [5:0] vec);
      // Two words per entry, so the table spans 2*NUM_VEC words from the base
      entry_addr = 21'((24'(base) << VPA_BASE_SHIFT) + 24'({vec, 1'b0}));
   endfunction

   function automatic logic [1:0] clamp_periph(input logic [1:0] l);
      clamp_periph = (l > VPA_LVL_PERIPH_MAX) ? VPA_LVL_PERIPH_MAX : l;
   endfunction

   function automatic logic [1:0] clamp_debug(input logic [1:0] l);
      clamp_debug = (l < VPA_LVL_DEBUG_MIN) ? VPA_LVL_DEBUG_MIN : l;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // External request: two-stage synchroniser, bypassed in low power
   logic ext_s1_reg;
   logic ext_s2_reg;
   logic ext_prev_reg;
   logic ext_pend_reg;
   logic ext_pend_next;
   logic ext_lvl_src;
   wire ext_active = ext_low_power_i ? ~external_request_a_n_i : ~ext_s2_reg;
   wire ext_fall = ext_active & ~ext_prev_reg;
   wire ext_taken;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ext_s1_reg <= 1'b1;
         ext_s2_reg <= 1'b1;
         ext_prev_reg <= 1'b0;
         ext_pend_reg <= 1'b0;
      end
      else
      begin
         ext_s1_reg <= external_request_a_n_i;
         ext_s2_reg <= ext_s1_reg;
         ext_prev_reg <= ext_active;
         ext_pend_reg <= ext_pend_next;
      end
   end

   // A new edge in the acknowledge cycle is kept: set beats clear
   always_comb
   begin
      ext_pend_next = ext_pend_reg;
      if (ext_taken)
      begin
         ext_pend_next = 1'b0;
      end
      if (ext_fall)
      begin
         ext_pend_next = 1'b1;
      end
   end
   assign ext_lvl_src = ext_edge_mode_i ? ext_pend_reg : ext_active;

   ////////////////////////////////////////////////////////////////////////////
   // Request and level table indexed by vector number
   logic [NUM_VEC-1:0] req_vec;
   logic [1:0] lvl_vec [NUM_VEC];
   localparam int PV [VPA_NUM_PER] = '{VPA_V_LOWV, VPA_V_CLKSYN, VPA_V_FL_ERR,
      VPA_V_FL_DONE, VPA_V_FL_EMPTY, VPA_V_CAN_OFF, VPA_V_CAN_ERR,
      VPA_V_CAN_WAKE, VPA_V_CAN_MB, VPA_V_PORT_C, VPA_V_PORT_B, VPA_V_PORT_A,
      VPA_V_SERIAL_PERIPH_UNIT_1_RX, VPA_V_SERIAL_PERIPH_UNIT_1_TX, VPA_V_SERIAL_PERIPH_UNIT_0_RX, VPA_V_SERIAL_PERIPH_UNIT_0_TX,
      VPA_V_ASU1_TX, VPA_V_ASU1_IDLE, 0, 0, 0, 0, 0, 0};
   localparam int PER_USED = 18;
   localparam int DV [5] = '{VPA_V_STEP, VPA_V_BKPT0, VPA_V_TRACE,
      VPA_V_TX_EMPTY, VPA_V_RX_FULL};
   localparam int CV [4] = '{VPA_V_ILLEGAL, VPA_V_SWI3, VPA_V_STACK, VPA_V_MISALIGN};

   // Unlisted and reserved vectors stay permanently idle
   always_comb
   begin
      req_vec = '0;
      for (int v = 0; v < NUM_VEC; v++)
      begin
         lvl_vec[v] = 2'h0;
      end
      for (int i = 0; i < 4; i++)
      begin
         req_vec[CV[i]] = core_exc_i[i];
         lvl_vec[CV[i]] = VPA_LVL_TOP;
      end
      for (int i = 0; i < 5; i++)
      begin
         req_vec[DV[i]] = debug_unit_req_i[i];
         lvl_vec[DV[i]] = clamp_debug(debug_unit_lvl_i[2*i +: 2]);
      end
      req_vec[VPA_V_EXT_A] = ext_lvl_src;
      lvl_vec[VPA_V_EXT_A] = clamp_periph(ext_lvl_i);
      for (int i = 0; i < PER_USED; i++)
      begin
         req_vec[PV[i]] = periph_req_i[i];
         lvl_vec[PV[i]] = clamp_periph(periph_lvl_i[2*i +: 2]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Winner: highest level, then lowest vector number
   logic win_found;
   logic [5:0] win_vec;
   logic [1:0] win_lvl;

   always_comb
   begin
      win_found = 1'b0;
      win_vec = 6'h00;
      win_lvl = 2'h0;
      for (int v = NUM_VEC - 1; v >= 0; v--)
      begin
         if (req_vec[v] && (!win_found || lvl_vec[v] >= win_lvl))
         begin
            win_found = 1'b1;
            win_vec = 6'(v);
            win_lvl = lvl_vec[v];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Presentation to the core, held until acknowledged
   vpa_state_e state_reg;
   logic valid_reg;
   logic [20:0] boot_addr_reg;
   logic [20:0] wdog_addr_reg;
   logic [5:0] vec_reg;
   logic [1:0] lvl_reg;
   logic [20:0] addr_reg;
   logic sec_reg;
   logic sec_loaded_reg;
   assign ext_taken = (state_reg == VPA_HOLD) && core_ack_i && (vec_reg == 6'(VPA_V_EXT_A));

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         state_reg <= VPA_IDLE;
         valid_reg <= 1'b0;
         vec_reg <= 6'h00;
         lvl_reg <= 2'h0;
         addr_reg <= 21'h00_0000;
      end
      else
      begin
         case (state_reg)
            VPA_IDLE:
            begin
               if (win_found)
               begin
                  state_reg <= VPA_HOLD;
                  valid_reg <= 1'b1;
                  vec_reg <= win_vec;
                  lvl_reg <= win_lvl;
                  addr_reg <= entry_addr(vector_base_address_i, win_vec);
               end
            end
            VPA_HOLD:
            begin
               if (core_ack_i)
               begin
                  state_reg <= VPA_IDLE;
                  valid_reg <= 1'b0;
               end
            end
            default:
            begin
               state_reg <= VPA_IDLE;
               valid_reg <= 1'b0;
            end
         endcase
      end
   end

   // Security state is caught after reset and not changed by later writes
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         sec_reg <= 1'b0;
         sec_loaded_reg <= 1'b0;
      end
      else if (!sec_loaded_reg)
      begin
         sec_reg <= flash_secure_i;
         sec_loaded_reg <= 1'b1;
      end
   end

   // Fixed entry points kept in flops so every output leaves a register
   always_ff @(posedge ref_clk_i)
   begin
      boot_addr_reg <= VPA_BOOT_LOC;
      wdog_addr_reg <= VPA_WDOG_LOC;
   end

   assign irq_valid_o = valid_reg;
   assign irq_vector_o = vec_reg;
   assign irq_level_o = lvl_reg;
   assign irq_addr_o = addr_reg;
   // Boot select has no effect: no external memory interface
   assign boot_addr_o = boot_addr_reg;
   assign wdog_addr_o = wdog_addr_reg;
   assign flash_security_bit_o = sec_reg;
   assign ext_pending_o = ext_pend_reg;

   ////////////////////////////////////////////////////////////////////////////
   a_hold_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_valid_o && !core_ack_i |=> irq_valid_o && $stable(irq_vector_o)
      && $stable(irq_level_o)) else $error("vector changed before ack");
   a_addr_form: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(irq_valid_o) |-> irq_addr_o == entry_addr($past(vector_base_address_i),
      irq_vector_o)) else $error("entry address wrong");
   a_core_top: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(irq_valid_o) && irq_vector_o inside {[2:5]} |-> irq_level_o == 2'h3)
      else $error("core exception not at level 3");
   a_level_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !irq_valid_o && core_exc_i != 4'h0 |=> irq_valid_o && irq_level_o == 2'h3)
      else $error("lower level won");
   a_lowest_vec: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !irq_valid_o && core_exc_i[0] |=> irq_vector_o == 6'd2)
      else $error("not smallest vector");
   a_periph_lvl: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_valid_o && irq_vector_o >= 6'd17 |-> irq_level_o <= 2'h2)
      else $error("peripheral level above 2");
   a_debug_lvl: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_valid_o && irq_vector_o inside {[6:11]} |-> irq_level_o >= 2'h1)
      else $error("debug level below 1");
   a_no_reserved: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_valid_o |-> !(irq_vector_o inside {0, 1, 8, 12, 13, 18, 19, 25, [30:32]}))
      else $error("reserved vector raised");
   a_sec_fixed: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      sec_loaded_reg ##1 mode_wr_i |=> $stable(flash_security_bit_o))
      else $error("security bit changed by write");
   a_boot_fixed: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      boot_addr_o == VPA_BOOT_LOC && wdog_addr_o == boot_addr_o + 21'h2)
      else $error("boot locations wrong");
   c_ext_edge: cover property (@(posedge ref_clk_i) ext_edge_mode_i && ext_fall);
   c_ack: cover property (@(posedge ref_clk_i) irq_valid_o && core_ack_i);
   c_core_win: cover property (@(posedge ref_clk_i) $rose(irq_valid_o)
      && irq_level_o == 2'h3);
   c_port_a: cover property (@(posedge ref_clk_i) irq_valid_o && irq_vector_o == 6'd35);
endmodule // vector_priority_arbiter

// ===== testbench/vpa_core_model.sv
/*
 Behavioural core that takes interrupt vectors from the arbiter.
 Assumes the arbiter clock and drives its acknowledge at the falling edge.
*/
module vpa_core_model
(
   // Clock
   input wire logic clk_i,
   // Request from the arbiter
   input wire logic valid_i,
   input wire logic [5:0] vec_i,
   // Stall set by the bench
   input wire logic [1:0] delay_i,
   // Acknowledge and what was taken
   output logic ack_o,
   output logic [5:0] ack_vec_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   initial ack_o = 1'b0;
   initial wait_cnt = 2'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // Stalls up to three cycles so a held vector is seen over several edges
   always @(negedge clk_i)
   begin
      if (ack_o)
      begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
      end
      else if (valid_i && wait_cnt >= delay_i)
         ack_o <= 1'b1;
      else if (valid_i)
         wait_cnt <= wait_cnt + 2'h1;
   end
   // Any presented vector is captured at the rising edge while ack is high
   always @(posedge clk_i)
      if (ack_o && valid_i)
         ack_vec_o <= vec_i;
endmodule // vpa_core_model

// ===== testbench/vector_priority_arbiter_tb_top.sv
/*
 Self-checking bench for the vector priority arbiter with a core model.
 Assumes requests are held by their sources until the vector is presented.
*/
module vector_priority_arbiter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import vpa_pkg::*;
   logic ref_clk_i, reset_i, external_request_a_n_i, ext_edge_mode_i, ext_low_power_i;
   logic boot_select_bit_i, flash_secure_i, mode_wr_i, mode_wr_data_i;
   logic [3:0] core_exc_i;
   logic [4:0] debug_unit_req_i;
   logic [9:0] debug_unit_lvl_i;
   logic [1:0] ext_lvl_i, ack_dly;
   logic [23:0] periph_req_i;
   logic [47:0] periph_lvl_i;
   logic [15:0] vector_base_address_i;
   logic core_ack_i, irq_valid_o, flash_security_bit_o, ext_pending_o;
   logic [5:0] irq_vector_o, ack_vec;
   logic [1:0] irq_level_o;
   logic [20:0] irq_addr_o, boot_addr_o, wdog_addr_o;
   int n_mismatch = 0, total_checks = 0, best_l, best_v;
   int per_vec[18] = '{20, 21, 22, 23, 24, 26, 27, 28, 29, 33, 34, 35, 38, 39, 40, 41, 42, 43};
   int dbg_vec[5] = '{6, 7, 9, 10, 11};
   vector_priority_arbiter dut (.ref_clk_i, .reset_i, .core_exc_i, .debug_unit_req_i,
      .debug_unit_lvl_i, .external_request_a_n_i, .ext_edge_mode_i, .ext_low_power_i,
      .ext_lvl_i, .periph_req_i, .periph_lvl_i, .vector_base_address_i, .boot_select_bit_i,
      .flash_secure_i, .mode_wr_i, .mode_wr_data_i, .core_ack_i, .irq_valid_o, .irq_vector_o,
      .irq_level_o, .irq_addr_o, .boot_addr_o, .wdog_addr_o, .flash_security_bit_o,
      .ext_pending_o);
   vpa_core_model core (.clk_i(ref_clk_i), .valid_i(irq_valid_o), .vec_i(irq_vector_o),
      .delay_i(ack_dly), .ack_o(core_ack_i), .ack_vec_o(ack_vec));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic void cand(int l, int v);
      if (l > best_l || (l == best_l && v < best_v))
      begin
         best_l = l;
         best_v = v;
      end
   endfunction
   // Out-of-range levels are clamped: debug up to 1, others down to 2
   function automatic void expect_winner();
      best_l = -1;
      best_v = 64;
      for (int i = 0; i < 4; i++) if (core_exc_i[i]) cand(3, 2 + i);
      for (int i = 0; i < 5; i++) if (debug_unit_req_i[i])
         cand(debug_unit_lvl_i[2*i+:2] == 0 ? 1 : debug_unit_lvl_i[2*i+:2], dbg_vec[i]);
      for (int i = 0; i < 18; i++) if (periph_req_i[i])
         cand(periph_lvl_i[2*i+:2] == 3 ? 2 : periph_lvl_i[2*i+:2], per_vec[i]);
      if (!external_request_a_n_i) cand(ext_lvl_i == 3 ? 2 : ext_lvl_i, 17);
   endfunction
   task automatic clear_req();
      core_exc_i = 4'h0;
      debug_unit_req_i = 5'h0;
      periph_req_i = 24'h00_0000;
      external_request_a_n_i = 1'b1;
   endtask
   // A late higher request must not disturb the vector already presented
   task automatic serve(input bit intrude);
      int n;
      n = 0;
      while (irq_valid_o !== 1'b1 && n < 20)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      check(irq_valid_o, 1);
      check(irq_vector_o, best_v);
      check(irq_level_o, best_l);
      check(irq_addr_o, {vector_base_address_i, 8'h00} + 2 * best_v);
      clear_req();
      if (intrude)
         core_exc_i = 4'h1;
      n = 0;
      while (irq_valid_o !== 1'b0 && n < 20)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      check(ack_vec, best_v);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial
   begin
      #200us;
      n_mismatch++;
      end_sim();
   end
   initial
   begin
      void'($urandom(63442));
      reset_i = 1'b1;
      clear_req();
      {ext_edge_mode_i, ext_low_power_i, boot_select_bit_i, mode_wr_i, mode_wr_data_i} = 5'h00;
      {ext_lvl_i, ack_dly, debug_unit_lvl_i, periph_lvl_i} = '0;
      vector_base_address_i = 16'h0200;
      flash_secure_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      reset_i = 1'b0;
      @(negedge ref_clk_i);
      check(irq_valid_o, 0);
      check(boot_addr_o, 32'h0002_0000);
      check(wdog_addr_o, 32'h0002_0002);
      check(wdog_addr_o, {vector_base_address_i, 8'h00} + 2);
      {boot_select_bit_i, mode_wr_i, flash_secure_i} = 3'b110;
      @(negedge ref_clk_i);
      mode_wr_i = 1'b0;
      @(negedge ref_clk_i);
      check(flash_security_bit_o, 1);
      check(boot_addr_o, {vector_base_address_i, 8'h00});
      for (int i = 0; i < 4; i++)
      begin
         core_exc_i = 4'h1 << i;
         expect_winner();
         serve(0);
      end
      for (int i = 0; i < 5; i++)
      begin
         debug_unit_req_i = 5'h01 << i;
         expect_winner();
         serve(0);
      end
      for (int i = 0; i < 18; i++)
      begin
         periph_req_i = 24'h00_0001 << i;
         periph_lvl_i = 48'({$urandom(), $urandom()});
         expect_winner();
         serve(0);
      end
      periph_req_i = 24'hFC_0000;
      repeat (10) @(negedge ref_clk_i);
      check(irq_valid_o, 0);
      ack_dly = 2'h3;
      periph_req_i = 24'h00_0001;
      expect_winner();
      serve(1);
      expect_winner();
      serve(0);
      for (int t = 0; t < 60; t++)
      begin
         ack_dly = 2'($urandom_range(3));
         vector_base_address_i = 16'($urandom_range(16'h1FFE));
         core_exc_i = ($urandom_range(5) == 0) ? 4'($urandom()) : 4'h0;
         debug_unit_req_i = 5'($urandom());
         debug_unit_lvl_i = 10'($urandom());
         periph_req_i = 24'($urandom());
         periph_req_i[$urandom_range(17)] = 1'b1;
         periph_lvl_i = 48'({$urandom(), $urandom()});
         expect_winner();
         serve(0);
      end
      {ext_low_power_i, ext_lvl_i, external_request_a_n_i} = 4'b0110;
      expect_winner();
      serve(0);
      {ext_low_power_i, ext_lvl_i, external_request_a_n_i} = 4'b1010;
      expect_winner();
      serve(0);
      {ext_edge_mode_i, ext_low_power_i, ext_lvl_i} = 4'b1001;
      external_request_a_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      external_request_a_n_i = 1'b1;
      best_l = 1;
      best_v = 17;
      serve(0);
      check(ext_pending_o, 0);
      end_sim();
   end
endmodule // vector_priority_arbiter_tb_top
